// *** tpes_prescaler.sv ***
/*
  Prescaler and valid-edge selection for one channel of the 16-bit
  timer/event counters. Holds the prescaler mode register, derives the
  count clock enable and the qualified edge pulses of both event inputs.
  Assumes a plain register port, run mode bits from the mode control
  register on the same clock, and asynchronous event pins.
*/
// Function
// - Mode register selects count clock and edges
// - Register accessible as byte or single bits
// - Reset clears register to all zeros
// - First enable with pin high reports rising if rising or both edges selected
// - Re-enable after stop reports no spurious edge
// - Bits 7:6 select second input edge
// - Bits 5:4 select first input edge
// - Channels 0,2: fxx/2,/4,/8 or pin
// - Channel 1: fxx,/4, watch tick, pin
// - Channel 3: fxx/4,/16,/512 or pin
// - Channel 4: fxx/2,/4,/8 or pin
`timescale 1ns/100ps
module tpes_prescaler
  import tpes_pkg::*;
#(
  parameter int unsigned       CHANNEL  = 2,            // Channel index, 0 to 5.
  parameter logic [ADDR_W-1:0] PRM_ADDR = PRM_CH2_ADDR  // Mode register address.
)
(
  // Clock and reset.
  input  wire logic              ref_clk,
  input  wire logic              rst_n,
  // Register port.
  input  wire logic [ADDR_W-1:0] reg_addr,
  input  wire logic [DATA_W-1:0] reg_wdata,
  input  wire logic [DATA_W-1:0] reg_bit_mask,
  input  wire logic              reg_wr,
  input  wire logic              reg_rd,
  output logic [DATA_W-1:0]      reg_rdata_q,
  // Run mode bits from the mode control register.
  input  wire logic              run_mode_bit_hi,
  input  wire logic              run_mode_bit_lo,
  // Watch-timer tick, one cycle wide, same clock.
  input  wire logic              watch_timer_tick,
  // Event pins.
  input  wire logic              first_event_input,
  input  wire logic              second_event_input,
  // Results towards the counter core.
  output logic                   count_tick_q,
  output logic                   first_edge_q,
  output logic                   second_edge_q,
  output tpes_prm_t              prm_cfg_q
);

  // Divider exponent for a channel and code; zero means every cycle.
  function automatic logic [3:0] div_exp(input int unsigned ch, input logic [1:0] code);
    logic [3:0] e;
    e = DIV_1;
    unique case (ch)
      0, 2, 4:
      begin
        e = (code == CLK_SEL_0) ? DIV_2 : (code == CLK_SEL_1) ? DIV_4 : DIV_8;
      end
      1:
      begin
        e = (code == CLK_SEL_0) ? DIV_1 : DIV_4;
      end
      3:
      begin
        e = (code == CLK_SEL_0) ? DIV_4 : (code == CLK_SEL_1) ? DIV_16 : DIV_512;
      end
      default:
      begin
        e = (code == CLK_SEL_0) ? DIV_1 : (code == CLK_SEL_1) ? DIV_4 : DIV_256;
      end
    endcase
    return e;
  endfunction

  // Whether an edge code accepts a rising or a falling change.
  // Shared by both pins and by the first-enable check, so it is a function.
  function automatic logic edge_hit(input logic [1:0] code, input logic rise, input logic fall);
    logic hit;
    hit = 1'b0;
    unique case (code)
      EDGE_FALL: hit = fall;
      EDGE_RISE: hit = rise;
      EDGE_BOTH: hit = rise | fall;
      EDGE_BAD:  hit = 1'b0;  // Prohibited code detects nothing.
    endcase
    return hit;
  endfunction

  // The status register sits one byte above the mode register. It is
  // read-only, and a read of it clears the refusal flag.
  localparam logic [ADDR_W-1:0] STATUS_ADDR = PRM_ADDR + STATUS_STEP;

  // Register state, run tracking, divider and pin sampler signals.
  tpes_prm_t          prm_q;          // Prescaler mode register.
  tpes_prm_t          prm_d;          // Its next value after a write.
  logic               run;            // Channel runs when mode bits are not 00.
  logic               run_prev_q;     // Run state one cycle earlier.
  logic               run_start;      // One-cycle pulse when running begins.
  logic               started_once_q; // Set on the very first enable.
  logic               wr_refused_q;   // Sticky: a write arrived while running.
  logic               bad_edge;       // A prohibited edge code is held.
  logic [PRESC_W-1:0] presc_q;        // Free prescale counter.
  logic [PRESC_W-1:0] div_mask;       // Low counter bits that must be ones.
  logic [3:0]         exp_sel;        // Exponent of the selected ratio.
  logic               div_tick;       // Divided clock enable.
  logic               prm_hit;        // Address selects the mode register.
  logic               st_hit;         // Address selects the status register.
  logic [DATA_W-1:0]  status;         // Status word as read.
  logic               first_lvl;      // Settled first pin level.
  logic               first_rise;     // First pin rising pulse.
  logic               first_fall;     // First pin falling pulse.
  logic               second_lvl;     // Settled second pin level.
  logic               second_rise;    // Second pin rising pulse.
  logic               second_fall;    // Second pin falling pulse.
  logic               first_hit;      // First pin qualified edge.
  logic               second_hit;     // Second pin qualified edge.

  // Sampler of the first event input.
  tpes_pin_sync u_first_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (first_event_input),
    .level_q (first_lvl),
    .rise_q  (first_rise),
    .fall_q  (first_fall)
  );

  // Sampler of the second event input.
  tpes_pin_sync u_second_sync (
    .ref_clk (ref_clk),
    .rst_n   (rst_n),
    .pin_in  (second_event_input),
    .level_q (second_lvl),
    .rise_q  (second_rise),
    .fall_q  (second_fall)
  );

  // Address decode and run state.
  // The run decode is combinational, since the mode bits share this clock.
  assign prm_hit   = (reg_addr == PRM_ADDR);
  assign st_hit    = (reg_addr == STATUS_ADDR);
  assign run       = ({run_mode_bit_hi, run_mode_bit_lo} != RUN_STOPPED);
  assign run_start = run & ~run_prev_q;
  assign bad_edge  = (prm_q.first_edge == EDGE_BAD) | (prm_q.second_edge == EDGE_BAD);

  // Merge a write into the register under the bit mask; a full mask is a
  // byte write, a single set bit a bit write. Reserved bits stay zero.
  always_comb
  begin
    prm_d = tpes_prm_t'(((prm_q & ~reg_bit_mask) | (reg_wdata & reg_bit_mask)) & PRM_WMASK);
  end

  // Prescaler mode register. Writes while running are dropped, since the
  // counter core would otherwise see its clock or edges change mid-count.
  // Such a write leaves its mark in the status register instead.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prm_q <= tpes_prm_t'(PRM_RESET);
    end
    else if (reg_wr && prm_hit && !run)
    begin
      prm_q <= prm_d;
    end
  end

  // Sticky flag for refused writes; a new refusal wins over the read clear.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_refused_q <= 1'b0;
    end
    else if (reg_wr && prm_hit && run)
    begin
      wr_refused_q <= 1'b1;
    end
    else if (reg_rd && st_hit)
    begin
      wr_refused_q <= 1'b0;
    end
  end

  // Run history: the spurious high-level edge is only due on the first
  // enable after reset, so the flag never clears until reset.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      run_prev_q     <= 1'b0;
      started_once_q <= 1'b0;
    end
    else
    begin
      run_prev_q <= run;
      if (run_start)
      begin
        started_once_q <= 1'b1;
      end
    end
  end

  // Prescale counter; held at zero while stopped so counting starts in
  // step with the enable.
  // One counter serves every ratio, so the table costs only a mask.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      presc_q <= '0;
    end
    else if (!run)
    begin
      presc_q <= '0;
    end
    else
    begin
      presc_q <= presc_q + PRESC_W'(1);
    end
  end

  // Divided clock enable from the selected ratio.
  always_comb
  begin
    exp_sel  = div_exp(CHANNEL, prm_q.clock_sel);
    div_mask = PRESC_W'((10'h001 << exp_sel) - 10'h001);
    div_tick = ((presc_q & div_mask) == div_mask);
  end

  // Qualified edges. On the first enable a pin already high counts as a
  // rising edge when rising or both edges are selected; later enables
  // see only genuine changes.
  always_comb
  begin
    first_hit  = edge_hit(prm_q.first_edge, first_rise, first_fall);
    second_hit = edge_hit(prm_q.second_edge, second_rise, second_fall);
    if (run_start && !started_once_q)
    begin
      first_hit  = first_hit | (first_lvl & edge_hit(prm_q.first_edge, 1'b1, 1'b0));
      second_hit = second_hit | (second_lvl & edge_hit(prm_q.second_edge, 1'b1, 1'b0));
    end
  end

  // Edge pulses towards the counter core, only while the channel runs.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      first_edge_q  <= 1'b0;
      second_edge_q <= 1'b0;
    end
    else
    begin
      first_edge_q  <= run & first_hit;
      second_edge_q <= run & second_hit;
    end
  end

  // Count clock enable. Code 11 counts first-pin edges; the pin is then
  // assumed not to also serve clear-and-start or capture, and its pulses
  // are assumed wide enough for the three-stage sampler.
  // The watch-timer tick is honoured on its own channel only.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      count_tick_q <= 1'b0;
    end
    else if (!run)
    begin
      count_tick_q <= 1'b0;
    end
    else if (prm_q.clock_sel == CLK_SEL_PIN)
    begin
      count_tick_q <= first_hit;
    end
    else if ((CHANNEL == WATCH_CH) && (prm_q.clock_sel == CLK_SEL_2))
    begin
      count_tick_q <= watch_timer_tick;
    end
    else
    begin
      count_tick_q <= div_tick;
    end
  end

  // Configuration copy for the counter core and the output stage, which
  // keeps the shared pin either an input or an output.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      prm_cfg_q <= tpes_prm_t'(PRM_RESET);
    end
    else
    begin
      prm_cfg_q <= prm_q;
    end
  end

  // Status word showing the block's own state.
  // Bits 7 and 6 have no source and read zero.
  always_comb
  begin
    status                = '0;
    status[ST_RUN]        = run;
    status[ST_FIRST_LVL]  = first_lvl;
    status[ST_SECOND_LVL] = second_lvl;
    status[ST_STARTED]    = started_once_q;
    status[ST_BAD_EDGE]   = bad_edge;
    status[ST_WR_REFUSED] = wr_refused_q;
  end

  // Read data in the cycle after the strobe; zero elsewhere and for
  // unmapped addresses.
  // Zero outside the answer cycle lets a wired-or read bus need no mux.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      reg_rdata_q <= '0;
    end
    else if (reg_rd && prm_hit)
    begin
      reg_rdata_q <= prm_q;
    end
    else if (reg_rd && st_hit)
    begin
      reg_rdata_q <= status;
    end
    else
    begin
      reg_rdata_q <= '0;
    end
  end

endmodule // tpes_prescaler

// *** tpes_pkg.sv ***
/*
  Package for the timer prescaler and edge select block: register addresses,
  field layout of the prescaler mode register, codes for clock and edge
  selection, divider exponents, bus widths and the prescale counter width.
  Assumes it is compiled before every design file of the block.
*/
package tpes_pkg;

  // Register bus widths.
  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 8;

  // Printed addresses of the prescaler mode registers of two channels.
  localparam logic [ADDR_W-1:0] PRM_CH2_ADDR = 32'hFFFFF627;
  localparam logic [ADDR_W-1:0] PRM_CH5_ADDR = 32'hFFFFF657;
  // Read-only status register, placed one byte above the mode register.
  localparam logic [ADDR_W-1:0] STATUS_STEP  = 32'h00000001;

  // Reset value of the prescaler mode register.
  localparam logic [DATA_W-1:0] PRM_RESET = 8'h00;
  // Bits that software may change; bits 3 and 2 are reserved and read zero.
  localparam logic [DATA_W-1:0] PRM_WMASK = 8'hF3;

  // Field positions of the prescaler mode register.
  localparam int unsigned SECOND_EDGE_LSB = 6;
  localparam int unsigned FIRST_EDGE_LSB  = 4;
  localparam int unsigned CLOCK_SEL_LSB   = 0;

  // Layout of the prescaler mode register.
  typedef struct packed {
    logic [1:0] second_edge; // Valid edge of the second event input.
    logic [1:0] first_edge;  // Valid edge of the first event input.
    logic [1:0] rsvd;        // Reserved, always zero.
    logic [1:0] clock_sel;   // Count clock selection.
  } tpes_prm_t;

  // Valid edge selection codes.
  localparam logic [1:0] EDGE_FALL = 2'h0;
  localparam logic [1:0] EDGE_RISE = 2'h1;
  localparam logic [1:0] EDGE_BAD  = 2'h2;
  localparam logic [1:0] EDGE_BOTH = 2'h3;

  // Count clock selection codes.
  localparam logic [1:0] CLK_SEL_0   = 2'h0;
  localparam logic [1:0] CLK_SEL_1   = 2'h1;
  localparam logic [1:0] CLK_SEL_2   = 2'h2;
  localparam logic [1:0] CLK_SEL_PIN = 2'h3;

  // Channel that offers the watch-timer tick on code 10.
  localparam int unsigned WATCH_CH = 1;

  // Divider exponents (log2 of the ratio) per channel and code.
  localparam logic [3:0] DIV_1   = 4'h0;
  localparam logic [3:0] DIV_2   = 4'h1;
  localparam logic [3:0] DIV_4   = 4'h2;
  localparam logic [3:0] DIV_8   = 4'h3;
  localparam logic [3:0] DIV_16  = 4'h4;
  localparam logic [3:0] DIV_256 = 4'h8;
  localparam logic [3:0] DIV_512 = 4'h9;
  // Width of the prescale counter, enough for the largest ratio.
  localparam int unsigned PRESC_W = 9;

  // Run mode value that means the channel is stopped.
  localparam logic [1:0] RUN_STOPPED = 2'h0;

  // Status register bit positions.
  localparam int unsigned ST_RUN       = 0;
  localparam int unsigned ST_FIRST_LVL = 1;
  localparam int unsigned ST_SECOND_LVL = 2;
  localparam int unsigned ST_STARTED   = 3;
  localparam int unsigned ST_BAD_EDGE  = 4;
  localparam int unsigned ST_WR_REFUSED = 5;

endpackage

// *** tpes_pin_sync.sv ***
/*
  Pin sampler for one event input: three flip-flops and a settled level that
  follows the pin once the second and third stage agree, with one-cycle
  rising and falling pulses on every accepted change.
  Assumes the pin is asynchronous to ref_clk and held for several cycles.
*/
`timescale 1ns/100ps
module tpes_pin_sync
  import tpes_pkg::*;
(
  // Clock and reset.
  input  wire logic ref_clk,
  input  wire logic rst_n,
  // Raw pin.
  input  wire logic pin_in,
  // Settled level and change pulses.
  output logic      level_q,
  output logic      rise_q,
  output logic      fall_q
);

  logic [2:0] sync_q; // Stage 0 is read only by stage 1.

  // Three-stage sampler; stage 0 meets metastability and feeds only stage 1.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sync_q <= 3'h0;
    end
    else
    begin
      sync_q <= {sync_q[1:0], pin_in};
    end
  end

  // A change is accepted once stages two and three agree on a new level.
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      level_q <= 1'b0;
      rise_q  <= 1'b0;
      fall_q  <= 1'b0;
    end
    else
    begin
      rise_q <= 1'b0;
      fall_q <= 1'b0;
      if ((sync_q[1] == sync_q[2]) && (sync_q[2] != level_q))
      begin
        level_q <= sync_q[2];
        rise_q  <= sync_q[2];
        fall_q  <= ~sync_q[2];
      end
    end
  end

endmodule // tpes_pin_sync

// *** tpes_prescaler_props.sv ***
/*
  Checker for the prescaler of one channel, bound to its ports.
  Assumes the divider table of channels 0, 2 and 4.
*/
`timescale 1ns/100ps
module tpes_prescaler_props
  import tpes_pkg::*;
#(
  parameter logic [ADDR_W-1:0] PRM_ADDR = PRM_CH2_ADDR  // Mode register address.
)
(
  // Clock and reset.
  input wire logic              ref_clk,
  input wire logic              rst_n,
  // Register port.
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic [DATA_W-1:0] reg_bit_mask,
  input wire logic              reg_wr,
  input wire logic              reg_rd,
  input wire logic [DATA_W-1:0] reg_rdata_q,
  // Run mode and results.
  input wire logic              run_mode_bit_hi,
  input wire logic              run_mode_bit_lo,
  input wire logic              count_tick_q,
  input wire logic              first_edge_q,
  input wire logic              second_edge_q,
  input wire tpes_prm_t         prm_cfg_q
);
  // One clock domain, so clock and reset are given once.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // The channel runs on any nonzero run code.
  logic run;
  assign run = run_mode_bit_hi | run_mode_bit_lo;

  property p_rd_stands;
    !$past(reg_rd) |-> reg_rdata_q == 8'h00;
  endproperty
  a_rd_stands: assert property (p_rd_stands) else $error("read data outside its cycle");
  property p_reset;
    $rose(rst_n) |-> prm_cfg_q == PRM_RESET;
  endproperty
  a_reset: assert property (p_reset) else $error("mode register not cleared");
  property p_wr_cfg;
    reg_wr && reg_addr == PRM_ADDR && reg_bit_mask == 8'hFF && !run ##1 !reg_wr
      |-> ##1 prm_cfg_q == ($past(reg_wdata, 2) & PRM_WMASK);
  endproperty
  a_wr_cfg: assert property (p_wr_cfg) else $error("byte write not taken");
  property p_refused;
    reg_wr && run |-> ##2 prm_cfg_q == $past(prm_cfg_q, 1);
  endproperty
  a_refused: assert property (p_refused) else $error("write taken while running");
  // A stopped channel gives no pulses; the check waits out the pipeline.
  property p_quiet;
    !$past(run, 1) && !$past(run, 2) |-> !first_edge_q && !second_edge_q && !count_tick_q;
  endproperty
  a_quiet: assert property (p_quiet) else $error("pulse while stopped");
  property p_div2;
    (run && prm_cfg_q.clock_sel == CLK_SEL_0)[*4] ##0 count_tick_q
      |-> $past(count_tick_q, 2) && !$past(count_tick_q);
  endproperty
  a_div2: assert property (p_div2) else $error("divide by 2 period wrong");
  // Consecutive earlier cycles spent running on code 10, saturating; it stands
  // in for a long repetition, which the tools would have to unroll.
  logic [3:0] div8_len_q;
  always_ff @(posedge ref_clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      div8_len_q <= 4'h0;
    end
    else if (run && prm_cfg_q.clock_sel == CLK_SEL_2)
    begin
      div8_len_q <= (div8_len_q == 4'hF) ? 4'hF : div8_len_q + 4'h1;
    end
    else
    begin
      div8_len_q <= 4'h0;
    end
  end
  property p_div8;
    run && prm_cfg_q.clock_sel == CLK_SEL_2 && div8_len_q >= 4'h9 && count_tick_q
      |-> $past(count_tick_q, 8) && !$past(count_tick_q, 4) && !$past(count_tick_q);
  endproperty
  a_div8: assert property (p_div8) else $error("divide by 8 period wrong");
  property p_pin_tick;
    run && $past(run) && prm_cfg_q.clock_sel == CLK_SEL_PIN && $past(prm_cfg_q.clock_sel) == CLK_SEL_PIN
      |-> count_tick_q == first_edge_q;
  endproperty
  a_pin_tick: assert property (p_pin_tick) else $error("pin clock differs from edge");
  property p_bad_edge;
    prm_cfg_q.first_edge == EDGE_BAD && $past(prm_cfg_q.first_edge) == EDGE_BAD |-> !first_edge_q;
  endproperty
  a_bad_edge: assert property (p_bad_edge) else $error("edge on prohibited code");
endmodule // tpes_prescaler_props

bind tpes_prescaler tpes_prescaler_props #(.PRM_ADDR(PRM_ADDR)) u_props
(
  .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
  .reg_bit_mask(reg_bit_mask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
  .run_mode_bit_hi(run_mode_bit_hi), .run_mode_bit_lo(run_mode_bit_lo), .count_tick_q(count_tick_q),
  .first_edge_q(first_edge_q), .second_edge_q(second_edge_q), .prm_cfg_q(prm_cfg_q)
);

// *** tpes_pin_model.sv ***
/*
  Far-side model of the two event pins of one channel.
  Assumes the bench asks for levels through two request inputs.
*/
`timescale 1ns/100ps
module tpes_pin_model
#(
  parameter int unsigned MIN_HOLD = 9  // Cycles a level is held at least.
)
(
  // Clock.
  input  wire logic ref_clk,
  // Requested levels.
  input  wire logic first_want,
  input  wire logic second_want,
  // Pins, used as inputs only, never as timer outputs.
  output logic      first_event_input,
  output logic      second_event_input
);
  int unsigned hold1 = 0;  // Cycles since the first pin changed.
  int unsigned hold2 = 0;  // Cycles since the second pin changed.
  initial
  begin
    first_event_input = 1'b0;
    second_event_input = 1'b0;
  end
  // Levels outlast two fxx/4 periods, so a fast request is delayed.
  always @(posedge ref_clk)
  begin
    hold1 <= hold1 + 1;
    hold2 <= hold2 + 1;
    if (first_want != first_event_input && hold1 >= MIN_HOLD)
    begin
      first_event_input <= first_want;
      hold1 <= 0;
    end
    if (second_want != second_event_input && hold2 >= MIN_HOLD)
    begin
      second_event_input <= second_want;
      hold2 <= 0;
    end
  end
endmodule // tpes_pin_model

// *** tb.sv ***
/*
  Self-checking bench for the prescaler of channel 2.
  Assumes the pin model and the bound checker are compiled with it.
*/
`timescale 1ns/100ps
`define CHK(a, b) begin tests_run++; if ((a) !== (b)) begin err_total++; $display("BAD %0t got %h want %h", $time, a, b); end end
module tb
  import tpes_pkg::*;
;
  logic              ref_clk, rst_n, reg_wr, reg_rd, run_hi, run_lo, watch_tick, want1, want2, rd_pend;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata, reg_bit_mask, reg_rdata_q, shadow;
  logic              pin1, pin2, tick_q, edge1_q, edge2_q;
  tpes_prm_t         cfg_q;
  int                err_total, tests_run, n_tick, n_e1, n_e2, e;
  integer            seed = 32'hB4B3;
  logic [7:0]        exp_q[$];  // Expected read data, oldest first.
  logic [7:0]        exp_v;     // Oldest note, taken off before the compare.

  initial
  begin
    ref_clk = 1'b0;
    forever #5 ref_clk = ~ref_clk;
  end
  tpes_prescaler #(.CHANNEL(2), .PRM_ADDR(PRM_CH2_ADDR)) uut
  (
    .ref_clk(ref_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_bit_mask(reg_bit_mask), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata_q(reg_rdata_q),
    .run_mode_bit_hi(run_hi), .run_mode_bit_lo(run_lo), .watch_timer_tick(watch_tick),
    .first_event_input(pin1), .second_event_input(pin2), .count_tick_q(tick_q),
    .first_edge_q(edge1_q), .second_edge_q(edge2_q), .prm_cfg_q(cfg_q)
  );
  tpes_pin_model u_pins
  (
    .ref_clk(ref_clk), .first_want(want1), .second_want(want2),
    .first_event_input(pin1), .second_event_input(pin2)
  );
  // The tick is unused on this channel but still toggles, to show it is ignored.
  always @(posedge ref_clk) watch_tick <= ($random(seed) % 5) == 0;

  // Read data stand one cycle after the strobe; pulses are only counted.
  always @(posedge ref_clk)
  begin
    if (rd_pend && exp_q.size() > 0)
    begin
      exp_v = exp_q.pop_front();
      `CHK(reg_rdata_q, exp_v)
    end
    rd_pend = reg_rd;
    n_tick += tick_q;
    n_e1 += edge1_q;
    n_e2 += edge2_q;
  end

  task automatic wr(input logic [7:0] d, input logic [7:0] m, input logic [ADDR_W-1:0] a = PRM_CH2_ADDR);
    @(posedge ref_clk);
    reg_wr <= 1'b1;
    reg_rd <= 1'b0;
    reg_addr <= a;
    reg_wdata <= d;
    reg_bit_mask <= m;
  endtask
  task automatic rd(input logic [7:0] x, input logic [ADDR_W-1:0] a = PRM_CH2_ADDR);
    @(posedge ref_clk);
    reg_rd <= 1'b1;
    reg_wr <= 1'b0;
    reg_addr <= a;
    exp_q.push_back(x);
  endtask
  // Lowers both strobes, then lets n more cycles pass.
  task automatic idle(input int n);
    @(posedge ref_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b0;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic run(input logic [1:0] code, input int n);
    @(posedge ref_clk);
    {run_hi, run_lo} <= code;
    repeat (n) @(posedge ref_clk);
  endtask
  task automatic pins(input logic a, input logic b, input int n);
    @(posedge ref_clk);
    want1 <= a;
    want2 <= b;
    repeat (n) @(posedge ref_clk);
  endtask
  // Cleared between edges so the monitor never adds in the same step.
  task automatic clr();
    @(negedge ref_clk);
    n_tick = 0;
    n_e1 = 0;
    n_e2 = 0;
  endtask
  task automatic give_verdict();
    $display("checks %0d mismatches %0d", tests_run, err_total);
    if (err_total == 0 && tests_run > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask

  initial
  begin
    {rst_n, reg_wr, reg_rd, run_hi, run_lo, want1, want2} = '0;
    {reg_addr, reg_wdata, reg_bit_mask} = '0;
    {err_total, tests_run, n_tick, n_e1, n_e2} = '0;
    repeat (16) @(posedge ref_clk);
    rst_n <= 1'b1;
    rd(PRM_RESET);
    rd(8'h00, PRM_CH2_ADDR + 32'h2);
    // First enable with both pins high reports one rising edge each.
    wr({EDGE_BOTH, EDGE_RISE, 2'h0, CLK_SEL_0}, 8'hFF);
    idle(0);
    pins(1'b1, 1'b1, 20);
    clr();
    run(2'h3, 10);
    `CHK(n_e1 + n_e2, 2)
    run(2'h0, 5);
    run(2'h1, 10);
    run(2'h0, 5);
    pins(1'b0, 1'b0, 20);
    `CHK(n_e1 + n_e2, 2)
    // Random byte writes, then an unmapped write that must change nothing.
    for (int i = 0; i < 4; i++)
    begin
      shadow = 8'($random(seed));
      wr(shadow, 8'hFF);
      rd(shadow & PRM_WMASK);
    end
    wr(8'hFF, 8'hFF, PRM_CH2_ADDR + 32'h2);
    rd(shadow & PRM_WMASK);
    // Single-bit sets and clears through the mask.
    wr(8'h00, 8'hFF);
    shadow = 8'h00;
    for (int i = 0; i < 16; i++)
    begin
      wr({8{i < 8}}, 8'h01 << i[2:0]);
      shadow[i[2:0]] = (i < 8) & PRM_WMASK[i[2:0]];
      rd(shadow);
    end
    idle(0);
    // Internal ratios 2, 4, 8 over 64 running cycles.
    for (int c = 0; c < 3; c++)
    begin
      wr({6'h00, c[1:0]}, 8'hFF);
      idle(0);
      clr();
      run(2'h1 + c[1:0], 64);
      run(2'h0, 4);
      `CHK(n_tick, 32 >> c)
    end
    // Every edge code with the first pin as clock; a write while running is dropped.
    for (int c = 0; c < 4; c++)
    begin
      shadow = {c[1:0], c[1:0], 2'h0, CLK_SEL_PIN}; // Pins only counted, never clear or capture.
      wr(shadow, 8'hFF);
      idle(0);
      clr();
      run(2'h3, 4);
      wr(~shadow, 8'hFF);
      idle(0);
      repeat (2)
      begin
        pins(1'b1, 1'b1, 12);
        pins(1'b0, 1'b0, 12);
      end
      run(2'h0, 6);
      rd(shadow & PRM_WMASK);
      rd((8'h01 << ST_STARTED) | (8'h01 << ST_WR_REFUSED) | ((c == 2) ? (8'h01 << ST_BAD_EDGE) : 8'h00),
         PRM_CH2_ADDR + STATUS_STEP);
      idle(2);
      e = (c == 2) ? 0 : (c == 3) ? 4 : 2;
      `CHK(n_e1, e)
      `CHK(n_e2, e)
      `CHK(n_tick, e)
    end
    idle(5);
    `CHK(exp_q.size(), 0)
    give_verdict();
  end
  // About 660 cycles are needed; some forty-five times that means a hang.
  initial
  begin
    repeat (30000) @(posedge ref_clk);
    err_total++;
    give_verdict();
  end
endmodule // tb
